// ### cache_coherency_defs.vh
`ifndef CACHE_COHERENCY_DEFS_VH
`define CACHE_COHERENCY_DEFS_VH

// ==========================================================================
// register offsets (byte addresses)
`define REG_CMD           8'h00
`define REG_STATUS        8'h04

// ==========================================================================
// command register fields
`define CMD_OP_LSB        0
`define CMD_OP_MSB        2
`define CMD_WAY_LSB       4
`define CMD_WAY_MSB       5
`define CMD_COPYBACK      6
`define CMD_HIT           7
`define CMD_SNOOP_LSB     8
`define CMD_SNOOP_MSB     9
`define CMD_LINE_SIZE     10
`define CMD_SNOOPABLE     11
`define CMD_MASK_LSB      12
`define CMD_MASK_MSB      15
`define CMD_RESET         32'h0000_0000

// ==========================================================================
// status register fields
`define STAT_STATE_LSB    0
`define STAT_STATE_MSB    7
`define STAT_DIRTY_LSB    8
`define STAT_DIRTY_MSB    23
`define STAT_BUSY         24
`define STAT_PBUF         25
`define STAT_WT_ERR       26

// ==========================================================================
// operation codes
`define OP_NONE           3'h0
`define OP_CPU_READ       3'h1
`define OP_CPU_WRITE      3'h2
`define OP_INVALIDATE     3'h3
`define OP_PUSH           3'h4
`define OP_SNOOP_READ     3'h5
`define OP_SNOOP_WRITE    3'h6

// ==========================================================================
// line states and snoop codes
`define LINE_INVALID      2'h0
`define LINE_VALID        2'h1
`define LINE_DIRTY        2'h2
`define SNOOP_LEAVE       2'h1
`define SNOOP_INVAL       2'h2

`endif

// ### line_state_store.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// valid and per-long-word dirty flags for the four ways of a set
module line_state_store (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        we,
    input  wire [1:0]  way,
    input  wire        wr_valid,
    input  wire [3:0]  wr_dirty,
    output reg  [3:0]  line_valid,
    output reg  [15:0] line_dirty,
    output reg  [7:0]  line_state
);

`include "cache_coherency_defs.vh"

    integer i;

    // dirty flags are only kept on a valid line, so no fourth state exists
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_valid <= 4'h0;
            line_dirty <= 16'h0000;
        end else if (ce && we) begin
            line_valid[way]        <= wr_valid;
            line_dirty[way*4 +: 4] <= wr_valid ? wr_dirty : 4'h0;
        end
    end

    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            if (!line_valid[i])
                line_state[i*2 +: 2] = `LINE_INVALID;
            else if (|line_dirty[i*4 +: 4])
                line_state[i*2 +: 2] = `LINE_DIRTY;
            else
                line_state[i*2 +: 2] = `LINE_VALID;
        end
    end

endmodule // line_state_store

`default_nettype wire

// ### snoop_decider.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// response of one hit line to a snooped access
module snoop_decider (
    input  wire       is_write,
    input  wire [1:0] code,
    input  wire       line_size,
    input  wire [3:0] dirty,
    input  wire [3:0] mask,
    output reg        act,
    output reg        keep_valid,
    output reg  [3:0] new_dirty,
    output reg        inhibit,
    output reg        source,
    output reg        sink
);

`include "cache_coherency_defs.vh"

    wire dirty_any = |dirty;
    wire snoop_on  = (code == `SNOOP_LEAVE) || (code == `SNOOP_INVAL);

    always @* begin
        act        = snoop_on;
        keep_valid = 1'b1;
        new_dirty  = dirty;
        inhibit    = 1'b0;
        source     = 1'b0;
        sink       = 1'b0;
        if (snoop_on && !is_write) begin
            inhibit    = dirty_any;
            source     = dirty_any;
            keep_valid = (code != `SNOOP_INVAL);
        end else if (snoop_on) begin
            if (code == `SNOOP_INVAL || line_size) begin
                keep_valid = 1'b0;
            end else if (!dirty_any) begin
                keep_valid = 1'b0;
            end else begin
                inhibit    = 1'b1;
                sink       = 1'b1;
                new_dirty  = dirty | mask;
            end
        end
    end

endmodule // snoop_decider

`default_nettype wire

// ### data_cache_line_coherency_fsm.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// coherency sequencer for one four-way data cache set, driven over apb
module data_cache_line_coherency_fsm (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        fill_ack,
    input  wire        push_ack,
    input  wire        word_ack,
    output reg         fill_req,
    output reg  [1:0]  fill_way,
    output reg         push_req,
    output reg         word_write_req,
    output reg         cpu_data_valid,
    output reg         inhibit_mem,
    output reg         source_data,
    output reg         sink_data
);

`include "cache_coherency_defs.vh"

    localparam [2:0] SEQ_IDLE   = 3'h0;
    localparam [2:0] SEQ_EXEC   = 3'h1;
    localparam [2:0] SEQ_FILL   = 3'h2;
    localparam [2:0] SEQ_PUSH   = 3'h3;
    localparam [2:0] SEQ_WWRITE = 3'h4;

    // a zero long-word mask still marks one word, so a copyback write always dirties
    function [3:0] lw_mask;
        input [3:0] m;
        begin
            lw_mask = (m == 4'h0) ? 4'h1 : m;
        end
    endfunction

    // ======================================================================
    // state
    reg  [2:0]  seq;
    reg  [31:0] cmd;
    reg         pbuf_valid;
    reg         wt_err;
    reg  [2:0]  next_seq;
    reg         next_pbuf_valid;
    reg         next_wt_err_set;
    reg         next_data_valid;
    reg         next_inhibit;
    reg         next_source;
    reg         next_sink;
    reg         st_we;
    reg         st_valid;
    reg  [3:0]  st_dirty;

    wire [3:0]  line_valid;
    wire [15:0] line_dirty;
    wire [7:0]  line_state;

    wire [2:0]  op        = cmd[`CMD_OP_MSB:`CMD_OP_LSB];
    wire [1:0]  way       = cmd[`CMD_WAY_MSB:`CMD_WAY_LSB];
    wire        copyback  = cmd[`CMD_COPYBACK];
    wire        hit       = cmd[`CMD_HIT];
    wire        snoopable = cmd[`CMD_SNOOPABLE];
    wire [3:0]  mask      = lw_mask(cmd[`CMD_MASK_MSB:`CMD_MASK_LSB]);
    wire        sel_valid = line_valid[way];
    wire [3:0]  sel_dirty = line_dirty[way*4 +: 4];
    wire        sel_dirty_any = sel_valid && (|sel_dirty);

    wire        sn_act;
    wire        sn_keep;
    wire [3:0]  sn_dirty;
    wire        sn_inhibit;
    wire        sn_source;
    wire        sn_sink;

    // ======================================================================
    // apb slave: one wait state, pready and prdata come from flops
    wire access    = psel && penable && pready;
    wire wr_cmd    = access && pwrite && (paddr == `REG_CMD);
    wire wr_status = access && pwrite && (paddr == `REG_STATUS);
    wire start     = wr_cmd && !pslverr; // busy is judged once, when pslverr is launched
    reg  [31:0] next_rdata;
    reg         next_err;

    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (paddr == `REG_CMD) begin
            next_rdata = cmd;
            next_err   = pwrite && (seq != SEQ_IDLE);
        end else if (paddr == `REG_STATUS) begin
            next_rdata[`STAT_STATE_MSB:`STAT_STATE_LSB] = line_state;
            next_rdata[`STAT_DIRTY_MSB:`STAT_DIRTY_LSB] = line_dirty;
            next_rdata[`STAT_BUSY]   = (seq != SEQ_IDLE);
            next_rdata[`STAT_PBUF]   = pbuf_valid;
            next_rdata[`STAT_WT_ERR] = wt_err;
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // ======================================================================
    // line storage and snoop response
    line_state_store u_store (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .we         (st_we),
        .way        (way),
        .wr_valid   (st_valid),
        .wr_dirty   (st_dirty),
        .line_valid (line_valid),
        .line_dirty (line_dirty),
        .line_state (line_state)
    );

    snoop_decider u_snoop (
        .is_write   (op == `OP_SNOOP_WRITE),
        .code       (cmd[`CMD_SNOOP_MSB:`CMD_SNOOP_LSB]),
        .line_size  (cmd[`CMD_LINE_SIZE]),
        .dirty      (sel_dirty),
        .mask       (mask),
        .act        (sn_act),
        .keep_valid (sn_keep),
        .new_dirty  (sn_dirty),
        .inhibit    (sn_inhibit),
        .source     (sn_source),
        .sink       (sn_sink)
    );

    // ======================================================================
    // sequencer
    always @* begin
        next_seq        = seq;
        next_pbuf_valid = pbuf_valid;
        next_wt_err_set = 1'b0;
        next_data_valid = 1'b0;
        next_inhibit    = 1'b0;
        next_source     = 1'b0;
        next_sink       = 1'b0;
        st_we           = 1'b0;
        st_valid        = sel_valid;
        st_dirty        = sel_dirty;
        case (seq)
            SEQ_IDLE: begin
                if (start)
                    next_seq = SEQ_EXEC;
            end
            SEQ_EXEC: begin
                next_seq = SEQ_IDLE;
                case (op)
                    `OP_CPU_READ, `OP_CPU_WRITE: begin
                        if (op == `OP_CPU_WRITE && !copyback) begin
                            next_wt_err_set = sel_dirty_any;
                            next_seq        = SEQ_WWRITE;
                        end else if (hit && op == `OP_CPU_READ) begin
                            next_data_valid = 1'b1;
                        end else if (hit) begin
                            st_we    = 1'b1;
                            st_valid = 1'b1;
                            st_dirty = sel_dirty | mask;
                        end else begin
                            // victim dirty data waits in the push buffer
                            next_pbuf_valid = sel_dirty_any;
                            st_we    = 1'b1;
                            st_valid = 1'b0;
                            st_dirty = 4'h0;
                            next_seq = SEQ_FILL;
                        end
                    end
                    `OP_INVALIDATE: begin
                        st_we    = 1'b1;
                        st_valid = 1'b0;
                        st_dirty = 4'h0;
                    end
                    `OP_PUSH: begin
                        next_pbuf_valid = sel_dirty_any;
                        st_we    = 1'b1;
                        st_valid = 1'b0;
                        st_dirty = 4'h0;
                        if (sel_dirty_any)
                            next_seq = SEQ_PUSH;
                    end
                    `OP_SNOOP_READ, `OP_SNOOP_WRITE: begin
                        if (snoopable && hit && sel_valid && sn_act) begin
                            st_we        = 1'b1;
                            st_valid     = sn_keep;
                            st_dirty     = sn_dirty;
                            next_inhibit = sn_inhibit;
                            next_source  = sn_source;
                            next_sink    = sn_sink;
                        end
                    end
                    default: begin
                        next_seq = SEQ_IDLE;
                    end
                endcase
            end
            SEQ_FILL: begin
                if (fill_ack) begin
                    st_we           = 1'b1;
                    st_valid        = 1'b1;
                    st_dirty        = (op == `OP_CPU_WRITE) ? mask : 4'h0;
                    next_data_valid = (op == `OP_CPU_READ);
                    next_seq        = pbuf_valid ? SEQ_PUSH : SEQ_IDLE;
                end
            end
            SEQ_PUSH: begin
                if (push_ack) begin
                    next_pbuf_valid = 1'b0;
                    next_seq        = SEQ_IDLE;
                end
            end
            SEQ_WWRITE: begin
                if (word_ack)
                    next_seq = SEQ_IDLE;
            end
            default: begin
                next_seq = SEQ_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq            <= SEQ_IDLE;
            cmd            <= `CMD_RESET;
            pbuf_valid     <= 1'b0;
            wt_err         <= 1'b0;
            fill_req       <= 1'b0;
            fill_way       <= 2'h0;
            push_req       <= 1'b0;
            word_write_req <= 1'b0;
            cpu_data_valid <= 1'b0;
            inhibit_mem    <= 1'b0;
            source_data    <= 1'b0;
            sink_data      <= 1'b0;
        end else if (ce) begin
            seq            <= next_seq;
            pbuf_valid     <= next_pbuf_valid;
            if (start)
                cmd <= pwdata;
            // a new error wins over a write-one clear in the same cycle
            if (next_wt_err_set)
                wt_err <= 1'b1;
            else if (wr_status && pwdata[`STAT_WT_ERR])
                wt_err <= 1'b0;
            fill_req       <= (next_seq == SEQ_FILL);
            fill_way       <= way;
            push_req       <= (next_seq == SEQ_PUSH);
            word_write_req <= (next_seq == SEQ_WWRITE);
            cpu_data_valid <= next_data_valid;
            inhibit_mem    <= next_inhibit;
            source_data    <= next_source;
            sink_data      <= next_sink;
        end
    end

endmodule // data_cache_line_coherency_fsm

`default_nettype wire

// ### dc_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "cache_coherency_defs.vh"
// ==========================================================================
// port-level checks on the cache line sequencer
module dc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fill_ack,
    input wire logic        push_ack,
    input wire logic        word_ack,
    input wire logic        fill_req,
    input wire logic [1:0]  fill_way,
    input wire logic        push_req,
    input wire logic        word_write_req,
    input wire logic        cpu_data_valid,
    input wire logic        inhibit_mem,
    input wire logic        source_data,
    input wire logic        sink_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_one_wait: assert property ((psel && penable && !$past(penable)) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_bad_addr: assert property ((psel && penable && pready && paddr != `REG_CMD
        && paddr != `REG_STATUS) |-> pslverr)
        else $error("unmapped access not refused");
    a_err_rdata: assert property ((pready && pslverr && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    a_fill_hold: assert property ((fill_req && !fill_ack) |=> fill_req)
        else $error("fill request dropped early");
    a_fill_end: assert property ((fill_req && fill_ack) |=> !fill_req)
        else $error("fill request held after ack");
    a_push_after_fill: assert property (push_req |-> !fill_req)
        else $error("push overlaps line fill");
    a_push_hold: assert property ((push_req && !push_ack) |=> push_req)
        else $error("push request dropped early");
    a_word_hold: assert property ((word_write_req && !word_ack) |=> word_write_req)
        else $error("word write dropped early");
    a_snoop_inhibit: assert property ((source_data || sink_data) |-> inhibit_mem)
        else $error("snoop data without memory inhibit");
endmodule // dc_checker

bind data_cache_line_coherency_fsm dc_checker chk_u (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fill_ack, .push_ack, .word_ack,
    .fill_req, .fill_way, .push_req, .word_write_req, .cpu_data_valid, .inhibit_mem,
    .source_data, .sink_data);
`default_nettype wire

// ### mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// memory side: answers each request level with a one-cycle ack after lat
module mem_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [2:0] req,
    input wire logic [3:0] lat,
    output logic     [2:0] ack
);
    logic [3:0] wait_cnt [3];
    logic [2:0] done;
    // done blocks a second ack while the requester is still dropping its level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 3'h0;
            done <= 3'h0;
            for (int i = 0; i < 3; i++) wait_cnt[i] <= 4'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                ack[i] <= 1'b0;
                if (!req[i]) begin
                    done[i] <= 1'b0;
                    wait_cnt[i] <= 4'h0;
                end else if (!done[i] && wait_cnt[i] >= lat) begin
                    ack[i] <= 1'b1;
                    done[i] <= 1'b1;
                end else if (!done[i]) begin
                    wait_cnt[i] <= wait_cnt[i] + 4'h1;
                end
            end
        end
    end
endmodule // mem_model
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cache_coherency_defs.vh"
// ==========================================================================
// self-checking bench for the cache line sequencer
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  lat = 4'h0;
    logic [31:0] prdata, rd, st;
    logic        pready, pslverr, er, fill_req, push_req, word_write_req;
    logic        cpu_data_valid, inhibit_mem, source_data, sink_data;
    logic [1:0]  fill_way;
    logic [2:0]  acks;
    logic [6:0]  ev_q = 7'h00;
    logic        ce = 1'b1;
    logic [1:0]  fway = 2'h0;
    int          cnt [7];
    int          fails = 0;
    int          compares = 0;
    wire  [6:0]  ev = {fill_req, push_req, word_write_req, cpu_data_valid,
                       inhibit_mem, source_data, sink_data};
    always #5 pclk = ~pclk;
    data_cache_line_coherency_fsm dut_u (.pclk, .presetn, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fill_ack(acks[2]),
        .push_ack(acks[1]), .word_ack(acks[0]), .fill_req, .fill_way, .push_req,
        .word_write_req, .cpu_data_valid, .inhibit_mem, .source_data, .sink_data);
    mem_model mem_u (.pclk, .presetn, .req({fill_req, push_req, word_write_req}),
        .lat, .ack(acks));
    // ======================================================================
    // event counters: each request level or pulse counted once per rise
    always @(posedge pclk) begin
        for (int i = 0; i < 7; i++) if (ev[i] && !ev_q[i]) cnt[i]++;
        ev_q <= ev;
        if (fill_req) fway <= fill_way;
    end
    // ======================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] cw(input logic [2:0] op, input logic [1:0] w,
        input logic cb, hit, input logic [1:0] sn, input logic ln, sp, input logic [3:0] m);
        return {m, sp, ln, sn, hit, cb, w, 1'b0, op};
    endfunction
    task automatic wait_idle();
        do apb(1'b0, `REG_STATUS, 32'h0); while (rd[`STAT_BUSY] !== 1'b0);
        st = rd;
    endtask
    task automatic cmd(input logic [15:0] c);
        for (int i = 0; i < 7; i++) cnt[i] = 0;
        apb(1'b1, `REG_CMD, {16'h0000, c});
        chk(er, 1'b0);
        wait_idle();
    endtask
    task automatic expect_line(input logic [1:0] w, input logic [1:0] s, input logic [3:0] d,
        input logic [6:0] e);
        chk(st[2*w +: 2], s);
        chk(st[8+4*w +: 4], d);
        for (int i = 0; i < 7; i++) chk(cnt[i], e[i]);
    endtask
    task automatic finish_test();
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ======================================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b1);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk(er, 1'b1);
    endtask
    task automatic t_cpu();
        lat <= 4'h3;
        cmd(cw(`OP_CPU_READ, 0, 0, 0, 0, 0, 0, 0));
        expect_line(0, `LINE_VALID, 0, 7'b1001000);
        cmd(cw(`OP_CPU_READ, 0, 0, 1, 0, 0, 0, 0));
        expect_line(0, `LINE_VALID, 0, 7'b0001000);
        cmd(cw(`OP_CPU_WRITE, 0, 0, 1, 0, 0, 0, 4'h1));
        expect_line(0, `LINE_VALID, 0, 7'b0010000);
        cmd(cw(`OP_CPU_WRITE, 2, 0, 0, 0, 0, 0, 4'h1));
        expect_line(2, `LINE_INVALID, 0, 7'b0010000);
        cmd(cw(`OP_CPU_WRITE, 1, 1, 0, 0, 0, 0, 4'h3));
        expect_line(1, `LINE_DIRTY, 4'h3, 7'b1000000);
        chk(fway, 2'h1);
        cmd(cw(`OP_CPU_WRITE, 0, 1, 1, 0, 0, 0, 4'h4));
        expect_line(0, `LINE_DIRTY, 4'h4, 7'b0000000);
        cmd(cw(`OP_CPU_WRITE, 1, 0, 1, 0, 0, 0, 4'h8));
        expect_line(1, `LINE_DIRTY, 4'h3, 7'b0010000);
        chk(st[`STAT_WT_ERR], 1'b1);
        apb(1'b1, `REG_STATUS, 32'h0400_0000);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd[`STAT_WT_ERR], 1'b0);
    endtask
    task automatic t_victims();
        lat <= 4'h7;
        cmd(cw(`OP_CPU_READ, 1, 0, 0, 0, 0, 0, 0));
        expect_line(1, `LINE_VALID, 0, 7'b1101000);
        cmd(cw(`OP_CPU_WRITE, 0, 1, 0, 0, 0, 0, 4'h2));
        expect_line(0, `LINE_DIRTY, 4'h2, 7'b1100000);
        chk(st[`STAT_PBUF], 1'b0);
        // a low clock enable must hold a started read hit in its execute cycle
        for (int i = 0; i < 7; i++) cnt[i] = 0;
        apb(1'b1, `REG_CMD, {16'h0000, cw(`OP_CPU_READ, 1, 0, 1, 0, 0, 0, 0)});
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(cnt[3], 0);
        ce <= 1'b1;
        wait_idle();
        chk(cnt[3], 1);
    endtask
    task automatic t_snoops();
        cmd(cw(`OP_SNOOP_READ, 0, 0, 1, 2, 1, 0, 0));
        expect_line(0, `LINE_DIRTY, 4'h2, 7'b0000000);
        cmd(cw(`OP_SNOOP_READ, 0, 0, 1, 1, 0, 1, 0));
        expect_line(0, `LINE_DIRTY, 4'h2, 7'b0000110);
        cmd(cw(`OP_SNOOP_READ, 1, 0, 1, 1, 0, 1, 0));
        expect_line(1, `LINE_VALID, 0, 7'b0000000);
        cmd(cw(`OP_SNOOP_WRITE, 0, 0, 1, 1, 0, 1, 4'h5));
        expect_line(0, `LINE_DIRTY, 4'h7, 7'b0000101);
        cmd(cw(`OP_SNOOP_WRITE, 0, 0, 1, 3, 0, 1, 4'h8));
        expect_line(0, `LINE_DIRTY, 4'h7, 7'b0000000);
        cmd(cw(`OP_SNOOP_READ, 0, 0, 1, 2, 1, 1, 0));
        expect_line(0, `LINE_INVALID, 0, 7'b0000110);
        cmd(cw(`OP_SNOOP_WRITE, 1, 0, 1, 1, 0, 1, 4'h1));
        expect_line(1, `LINE_INVALID, 0, 7'b0000000);
        cmd(cw(`OP_CPU_WRITE, 2, 1, 0, 0, 0, 0, 4'h1));
        cmd(cw(`OP_SNOOP_WRITE, 2, 0, 1, 1, 1, 1, 4'hF));
        expect_line(2, `LINE_INVALID, 0, 7'b0000000);
        cmd(cw(`OP_CPU_READ, 1, 0, 0, 0, 0, 0, 0));
        cmd(cw(`OP_SNOOP_WRITE, 1, 0, 1, 2, 0, 1, 4'h1));
        expect_line(1, `LINE_INVALID, 0, 7'b0000000);
    endtask
    task automatic t_maint();
        lat <= 4'hF;
        cmd(cw(`OP_CPU_WRITE, 3, 1, 0, 0, 0, 0, 4'h8));
        chk(fway, 2'h3);
        apb(1'b1, `REG_CMD, {16'h0000, cw(`OP_PUSH, 3, 0, 0, 0, 0, 0, 0)});
        apb(1'b1, `REG_CMD, {16'h0000, cw(`OP_INVALIDATE, 3, 0, 0, 0, 0, 0, 0)});
        chk(er, 1'b1);
        wait_idle();
        chk(st[7:6], `LINE_INVALID);
        chk(cnt[5], 1);
        cmd(cw(`OP_CPU_READ, 3, 0, 0, 0, 0, 0, 0));
        cmd(cw(`OP_PUSH, 3, 0, 0, 0, 0, 0, 0));
        expect_line(3, `LINE_INVALID, 0, 7'b0000000);
        cmd(cw(`OP_CPU_WRITE, 3, 1, 0, 0, 0, 0, 4'h1));
        cmd(cw(`OP_INVALIDATE, 3, 0, 0, 0, 0, 0, 0));
        expect_line(3, `LINE_INVALID, 0, 7'b0000000);
    endtask
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cpu();
        t_victims();
        t_snoops();
        t_maint();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
